// File: urtev_cfg.svh
`ifndef URTEV_CFG_SVH
`define URTEV_CFG_SVH
// register byte offsets
`define URTEV_OFF_RXHOLD     8'h00
`define URTEV_OFF_IDENT      8'h04
`define URTEV_OFF_LINESTATE  8'h08
`define URTEV_OFF_MODEMSTATE 8'h0C
`define URTEV_OFF_EXTCTL2    8'h10
`define URTEV_OFF_TOUT_HI    8'h14
`define URTEV_OFF_TOUT_LO    8'h18
`define URTEV_OFF_TRIGLVL    8'h1C
`define URTEV_OFF_IRQ_STAT   8'h20
`define URTEV_OFF_IRQ_MASK   8'h24
`define URTEV_OFF_FIFOSTAT   8'h28
// field positions
`define URTEV_PERIODIC_BIT   6
// reset values
`define URTEV_TOUT_HI_RST    8'h00
`define URTEV_TOUT_LO_RST    8'h40
`define URTEV_TRIGLVL_RST    8'h11
// interrupt status bits
`define URTEV_IRQ_TOUT       0
`define URTEV_IRQ_RXDMA      1
`define URTEV_IRQ_TXDMA      2
// ident register codes
`define URTEV_IDENT_NONE     8'h01
`define URTEV_IDENT_TOUT     8'h0C
// axi responses
`define URTEV_RESP_OKAY      2'h0
`define URTEV_RESP_SLVERR    2'h2
`endif

// File: urtev_pkg.sv
package urtev_pkg;
   typedef struct packed {
      logic       push;
      logic [7:0] data;
   } urtev_rx_char_t;

   typedef struct packed {
      logic       rx_req;
      logic       tx_req;
   } urtev_dma_req_t;

   typedef enum logic [0:0] {URTEV_AXI_IDLE, URTEV_AXI_RESP} urtev_axi_st_t;
endpackage

// File: urtev_fifo_mem.sv
module urtev_fifo_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 64
) (
   input  wire logic                     clk,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data_ff
);
   logic [WIDTH-1:0] mem [DEPTH];

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("depth must be power of two");
   end

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // registered read, address is the next head so data is ready on pop
   always_ff @(posedge clk) begin
      rd_data_ff <= mem[rd_addr];
   end
endmodule

// File: urtev_top.sv
// Behaviour
// - status reads never touch the timeout flag
// - timeout count split over high/low registers
// - control bit 6 selects periodic timeout mode
// - ident register read clears timeout flag, not its interrupt status bit
// - pending data re-raises timeout after clear
// - periodic mode re-raises timeout each expiry
// - trigger register drives DMA request thresholds
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "urtev_cfg.svh"
module urtev_top #(
   parameter int DEPTH = 64
) (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   output logic [1:0]                  s_axi_bresp,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   input  wire logic [7:0]             s_axi_araddr,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   input  wire urtev_pkg::urtev_rx_char_t rx_char,
   input  wire logic                   tx_pop,
   input  wire logic [6:0]             tx_level,
   input  wire logic [7:0]             line_state,
   input  wire logic [7:0]             modem_state,
   output urtev_pkg::urtev_dma_req_t   dma_req_ff,
   output logic                        irq_ff
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 32 || DEPTH > 64) begin
      $error("depth must cover trigger level 32");
   end

   // registers
   logic [7:0]  extended_feature_ctl_two_ff;
   logic [7:0]  rx_timeout_count_high_ff;
   logic [7:0]  rx_timeout_count_low_ff;
   logic [7:0]  fifo_trigger_level_reg_ff;
   logic [2:0]  irq_stat_ff;
   logic [2:0]  irq_mask_ff;
   logic        tout_flag_ff;

   // fifo state
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0]   rx_count_ff;
   logic [7:0]    rd_data;
   logic [15:0]   tout_cnt_ff;

   // synchronisers for pin-level status inputs
   logic [7:0] line_meta_ff;
   logic [7:0] line_sync_ff;
   logic [7:0] modem_meta_ff;
   logic [7:0] modem_sync_ff;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         line_meta_ff  <= 8'h00;
         line_sync_ff  <= 8'h00;
         modem_meta_ff <= 8'h00;
         modem_sync_ff <= 8'h00;
      end else begin
         line_meta_ff  <= line_state;
         line_sync_ff  <= line_meta_ff;
         modem_meta_ff <= modem_state;
         modem_sync_ff <= modem_meta_ff;
      end
   end

   // axi write channel
   logic       aw_held_ff;
   logic [7:0] aw_addr_ff;
   logic       w_held_ff;
   logic [31:0] w_data_ff;
   logic [3:0]  w_strb_ff;
   logic        wr_fire;

   assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_held_ff    <= 1'b0;
         aw_addr_ff    <= 8'h00;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_ff && !s_axi_awready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff    <= 1'b1;
            aw_addr_ff    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         w_held_ff    <= 1'b0;
         w_data_ff    <= 32'h0000_0000;
         w_strb_ff    <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held_ff && !s_axi_wready;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff    <= 1'b1;
            w_data_ff    <= s_axi_wdata;
            w_strb_ff    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_fire) begin
            w_held_ff <= 1'b0;
         end
      end
   end

   logic wr_known;
   always_comb begin
      unique case (aw_addr_ff)
         `URTEV_OFF_EXTCTL2, `URTEV_OFF_TOUT_HI, `URTEV_OFF_TOUT_LO,
         `URTEV_OFF_TRIGLVL, `URTEV_OFF_IRQ_STAT, `URTEV_OFF_IRQ_MASK: wr_known = 1'b1;
         default: wr_known = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `URTEV_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_known ? `URTEV_RESP_OKAY : `URTEV_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic wr_lane0;
   assign wr_lane0 = wr_fire && w_strb_ff[0];

   // control registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         extended_feature_ctl_two_ff <= 8'h00;
         rx_timeout_count_high_ff    <= `URTEV_TOUT_HI_RST;
         rx_timeout_count_low_ff     <= `URTEV_TOUT_LO_RST;
         fifo_trigger_level_reg_ff   <= `URTEV_TRIGLVL_RST;
         irq_mask_ff                 <= 3'h0;
      end else if (wr_lane0) begin
         unique case (aw_addr_ff)
            `URTEV_OFF_EXTCTL2:  extended_feature_ctl_two_ff <= w_data_ff[7:0];
            `URTEV_OFF_TOUT_HI:  rx_timeout_count_high_ff    <= w_data_ff[7:0];
            `URTEV_OFF_TOUT_LO:  rx_timeout_count_low_ff     <= w_data_ff[7:0];
            `URTEV_OFF_TRIGLVL:  fifo_trigger_level_reg_ff   <= w_data_ff[7:0];
            `URTEV_OFF_IRQ_MASK: irq_mask_ff                 <= w_data_ff[2:0];
            default: ;
         endcase
      end
   end

   // axi read channel
   logic       rd_fire;
   logic [7:0] ar_addr;
   logic       rd_hold_pop;
   logic       rd_ident;
   urtev_pkg::urtev_axi_st_t rd_st_ff;

   assign ar_addr     = s_axi_araddr;
   assign rd_fire     = s_axi_arvalid && s_axi_arready;
   assign rd_hold_pop = rd_fire && ar_addr == `URTEV_OFF_RXHOLD && rx_count_ff != '0;
   assign rd_ident    = rd_fire && ar_addr == `URTEV_OFF_IDENT;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_st_ff      <= urtev_pkg::URTEV_AXI_IDLE;
         s_axi_arready <= 1'b0;
      end else begin
         unique case (rd_st_ff)
            urtev_pkg::URTEV_AXI_IDLE: begin
               s_axi_arready <= !rd_fire;
               if (rd_fire) begin
                  rd_st_ff <= urtev_pkg::URTEV_AXI_RESP;
               end
            end
            urtev_pkg::URTEV_AXI_RESP: begin
               if (s_axi_rvalid && s_axi_rready) begin
                  rd_st_ff <= urtev_pkg::URTEV_AXI_IDLE;
               end
            end
         endcase
      end
   end

   logic [31:0] rd_mux;
   logic        rd_known;
   always_comb begin
      rd_mux   = 32'h0000_0000;
      rd_known = 1'b1;
      unique case (ar_addr)
         `URTEV_OFF_RXHOLD:     rd_mux[7:0] = rd_data;
         `URTEV_OFF_IDENT:      rd_mux[7:0] = tout_flag_ff ? `URTEV_IDENT_TOUT : `URTEV_IDENT_NONE;
         `URTEV_OFF_LINESTATE:  rd_mux[7:0] = {line_sync_ff[7:1], rx_count_ff != '0};
         `URTEV_OFF_MODEMSTATE: rd_mux[7:0] = modem_sync_ff;
         `URTEV_OFF_EXTCTL2:    rd_mux[7:0] = extended_feature_ctl_two_ff;
         `URTEV_OFF_TOUT_HI:    rd_mux[7:0] = rx_timeout_count_high_ff;
         `URTEV_OFF_TOUT_LO:    rd_mux[7:0] = rx_timeout_count_low_ff;
         `URTEV_OFF_TRIGLVL:    rd_mux[7:0] = fifo_trigger_level_reg_ff;
         `URTEV_OFF_IRQ_STAT:   rd_mux[2:0] = irq_stat_ff;
         `URTEV_OFF_IRQ_MASK:   rd_mux[2:0] = irq_mask_ff;
         `URTEV_OFF_FIFOSTAT:   rd_mux[AW:0] = rx_count_ff;
         default:               rd_known = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `URTEV_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_known ? `URTEV_RESP_OKAY : `URTEV_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // receive fifo; a push into a full fifo is dropped
   logic push_ok;
   assign push_ok = rx_char.push && rx_count_ff != (AW+1)'(DEPTH);

   urtev_fifo_mem #(
      .WIDTH(8),
      .DEPTH(DEPTH)
   ) u_rx_mem (
      .clk       (clk),
      .wr_en     (push_ok),
      .wr_addr   (wr_ptr_ff),
      .wr_data   (rx_char.data),
      .rd_addr   (rd_hold_pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff),
      .rd_data_ff(rd_data)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_ff   <= '0;
         rd_ptr_ff   <= '0;
         rx_count_ff <= '0;
      end else begin
         if (push_ok) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (rd_hold_pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         rx_count_ff <= rx_count_ff + (AW+1)'(push_ok) - (AW+1)'(rd_hold_pop);
      end
   end

   // timeout counter
   logic [15:0] tout_load;
   logic        periodic;
   logic        tout_expire;
   assign tout_load   = {rx_timeout_count_high_ff, rx_timeout_count_low_ff};
   assign periodic    = extended_feature_ctl_two_ff[`URTEV_PERIODIC_BIT];
   // a zero count still waits one cycle after each reload, as a count of one does
   assign tout_expire = tout_cnt_ff <= 16'h0001 && (periodic || rx_count_ff != '0);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tout_cnt_ff <= 16'h0000;
      end else if (rx_char.push || rd_hold_pop) begin
         tout_cnt_ff <= tout_load;
      end else if (tout_expire) begin
         tout_cnt_ff <= tout_load;
      end else if (!periodic && rx_count_ff == '0) begin
         tout_cnt_ff <= tout_load;
      end else if (tout_cnt_ff != 16'h0000) begin
         tout_cnt_ff <= tout_cnt_ff - 16'h0001;
      end
   end

   // timeout flag: only expiry sets it, only ident read clears it; set wins
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tout_flag_ff <= 1'b0;
      end else if (tout_expire) begin
         tout_flag_ff <= 1'b1;
      end else if (rd_ident) begin
         tout_flag_ff <= 1'b0;
      end
   end

   // dma requests from trigger levels; low nibble rx, high nibble tx, times four
   logic [6:0] rx_trig;
   logic [6:0] tx_trig;
   logic       rx_level_hit;
   logic       tx_level_hit;
   assign rx_trig      = {1'b0, fifo_trigger_level_reg_ff[3:0], 2'b00};
   assign tx_trig      = {1'b0, fifo_trigger_level_reg_ff[7:4], 2'b00};
   assign rx_level_hit = 7'(rx_count_ff) >= (rx_trig == 7'h00 ? 7'h01 : rx_trig);
   assign tx_level_hit = tx_level >= (tx_trig == 7'h00 ? 7'h01 : tx_trig);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dma_req_ff <= '0;
      end else begin
         dma_req_ff.rx_req <= rx_level_hit;
         dma_req_ff.tx_req <= tx_level_hit;
      end
   end

   // sticky interrupt status, write one to clear, set wins
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   assign irq_set = {tx_level_hit && !dma_req_ff.tx_req, rx_level_hit && !dma_req_ff.rx_req, tout_expire};
   assign irq_clr = (wr_lane0 && aw_addr_ff == `URTEV_OFF_IRQ_STAT) ? w_data_ff[2:0] : 3'h0;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_stat_ff <= 3'h0;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_mask_ff);
      end
   end
endmodule

// File: urtev_top_sva.sv
`include "urtev_cfg.svh"
module urtev_top_sva #(
   parameter int DEPTH = 64
) (
   input wire logic                      clk,
   input wire logic                      sys_rst,
   input wire logic                      s_axi_awvalid,
   input wire logic                      s_axi_awready,
   input wire logic [7:0]                s_axi_awaddr,
   input wire logic                      s_axi_wvalid,
   input wire logic                      s_axi_wready,
   input wire logic [31:0]               s_axi_wdata,
   input wire logic [3:0]                s_axi_wstrb,
   input wire logic                      s_axi_bvalid,
   input wire logic                      s_axi_bready,
   input wire logic [1:0]                s_axi_bresp,
   input wire logic                      s_axi_arvalid,
   input wire logic                      s_axi_arready,
   input wire logic [7:0]                s_axi_araddr,
   input wire logic                      s_axi_rvalid,
   input wire logic                      s_axi_rready,
   input wire logic [31:0]               s_axi_rdata,
   input wire logic [1:0]                s_axi_rresp,
   input wire urtev_pkg::urtev_rx_char_t rx_char,
   input wire logic                      tx_pop,
   input wire logic [6:0]                tx_level,
   input wire logic [7:0]                line_state,
   input wire logic [7:0]                modem_state,
   input wire urtev_pkg::urtev_dma_req_t dma_req_ff,
   input wire logic                      irq_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_id_take;
      s_rd_take ##0 (s_axi_araddr == `URTEV_OFF_IDENT);
   endsequence
   sequence s_bad_take;
      s_rd_take ##0 (s_axi_araddr >= 8'h2C);
   endsequence
   property p_rd_lat;
      s_rd_take |=> s_axi_rvalid;
   endproperty
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_bad_rd;
      s_bad_take |=> s_axi_rresp == `URTEV_RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   property p_ident;
      s_id_take |=> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[7:0] inside {`URTEV_IDENT_TOUT, `URTEV_IDENT_NONE};
   endproperty
   property p_tx_low;
      (tx_level == 7'h00) [*2] |-> !dma_req_ff.tx_req;
   endproperty
   property p_tx_high;
      (tx_level >= 7'h40) [*2] |-> dma_req_ff.tx_req;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   a_ar_block: assert property (p_ar_block) else $error("second read taken early");
   a_r_hold: assert property (p_r_hold) else $error("read answer changed");
   a_b_hold: assert property (p_b_hold) else $error("write answer changed");
   a_bad_rd: assert property (p_bad_rd) else $error("unmapped read answered");
   a_ident: assert property (p_ident) else $error("bad ident code");
   a_tx_low: assert property (p_tx_low) else $error("tx request below level");
   a_tx_high: assert property (p_tx_high) else $error("tx request missing");
endmodule
bind urtev_top urtev_top_sva #(.DEPTH(DEPTH)) i_urtev_top_sva (.*);

// File: urtev_line_model.sv
module urtev_line_model (
   input  wire logic                 clk,
   output urtev_pkg::urtev_rx_char_t rx_char,
   output logic [6:0]                tx_level,
   output logic [7:0]                line_state,
   output logic [7:0]                modem_state
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx_char = '0;
      tx_level = 7'h00;
      line_state = 8'h00;
      modem_state = 8'h00;
   end
   // pins wander so status reads see live values
   always @(posedge clk) begin
      modem_state <= modem_state + 8'h01;
      line_state <= line_state ^ 8'h3C;
   end
   task automatic send(input logic [7:0] d);
      @(posedge clk);
      rx_char <= '{push: 1'b1, data: d};
      @(posedge clk);
      rx_char <= '{push: 1'b0, data: ~d};
   endtask
   task automatic set_tx(input logic [6:0] l);
      @(posedge clk);
      tx_level <= l;
   endtask
endmodule

// File: uart_rx_timeout_dma_events_test.sv
`include "urtev_cfg.svh"
module uart_rx_timeout_dma_events_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} urtev_exp_t;
   logic                      clk, sys_rst, tx_pop, irq_ff;
   logic                      s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic                      s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]                s_axi_awaddr, s_axi_araddr, line_state, modem_state;
   logic [31:0]               s_axi_wdata, s_axi_rdata, seed, d;
   logic [3:0]                s_axi_wstrb;
   logic [1:0]                s_axi_bresp, s_axi_rresp;
   logic [6:0]                tx_level;
   urtev_pkg::urtev_rx_char_t rx_char;
   urtev_pkg::urtev_dma_req_t dma_req_ff;
   urtev_exp_t                e, rq[$];
   logic [1:0]                wq[$];
   logic [7:0]                rxd[4];
   int                        n_fail, checks, lvl;
   int                        fl[5] = '{0, 1, 2, 4, 8};
   urtev_top i_urtev_top (.*);
   urtev_line_model i_urtev_line_model (.clk(clk), .rx_char(rx_char), .tx_level(tx_level),
                                        .line_state(line_state), .modem_state(modem_state));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      checks++;
      if (g !== x) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tmo();
      chk(0, 1, "wait ran out");
      tally_and_finish();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] w, input logic [1:0] r = `URTEV_RESP_OKAY);
      int n;
      n = 0;
      // one edge between calls so no strobe is assigned twice in a step
      @(posedge clk);
      wq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= w;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bready && s_axi_bvalid) s_axi_bready <= 1'b0;
         if (n > 50) tmo();
      end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFF,
                     input logic [1:0] r = `URTEV_RESP_OKAY);
      int n;
      n = 0;
      @(posedge clk);
      rq.push_back('{r, x, m});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rready && s_axi_rvalid) s_axi_rready <= 1'b0;
         if (n > 50) tmo();
      end while (s_axi_arvalid || s_axi_rready);
   endtask
   task automatic wait_irq(input logic v, input int lim);
      int n;
      n = 0;
      while (irq_ff !== v) begin
         @(posedge clk);
         n++;
         if (n > lim) tmo();
      end
      chk(32'(irq_ff), 32'(v), "irq level");
   endtask
   task automatic hold_irq(input logic v, input int cyc);
      int bad;
      bad = 0;
      repeat (cyc) begin
         @(posedge clk);
         if (irq_ff !== v) bad++;
      end
      chk(bad, 0, "irq moved");
   endtask
   // results are matched in issue order; one read and one write at most in flight
   always @(posedge clk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         if (rq.size() == 0) chk(0, 1, "read without request");
         else begin
            e = rq.pop_front();
            chk({30'h0, s_axi_rresp}, {30'h0, e.resp}, "rresp");
            chk(s_axi_rdata & e.mask, e.data & e.mask, "rdata");
         end
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
         if (wq.size() == 0) chk(0, 1, "write without request");
         else chk({30'h0, s_axi_bresp}, {30'h0, wq.pop_front()}, "bresp");
      end
   end
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      seed = 32'h0000005A;
      sys_rst = 1'b1;
      tx_pop = 1'b0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(`URTEV_OFF_TOUT_HI, `URTEV_TOUT_HI_RST, 32'hFFFFFFFF);
      rd(`URTEV_OFF_TOUT_LO, `URTEV_TOUT_LO_RST, 32'hFFFFFFFF);
      rd(`URTEV_OFF_TRIGLVL, `URTEV_TRIGLVL_RST, 32'hFFFFFFFF);
      rd(8'h40, 32'h0, 32'hFFFFFFFF, `URTEV_RESP_SLVERR);
      wr(8'h40, rnd(), `URTEV_RESP_SLVERR);
      repeat (3) begin
         d = rnd();
         wr(`URTEV_OFF_TOUT_HI, d[15:8]);
         wr(`URTEV_OFF_TOUT_LO, d[7:0]);
         rd(`URTEV_OFF_TOUT_HI, d[15:8]);
         rd(`URTEV_OFF_TOUT_LO, d[7:0]);
      end
      wr(`URTEV_OFF_TOUT_HI, 32'h0);
      wr(`URTEV_OFF_TOUT_LO, 32'h30);
      wr(`URTEV_OFF_IRQ_MASK, 32'h1);
      d = rnd();
      i_urtev_line_model.send(d[7:0]);
      hold_irq(1'b0, 30);
      i_urtev_line_model.send(d[15:8]);
      hold_irq(1'b0, 40);
      wait_irq(1'b1, 60);
      rd(`URTEV_OFF_LINESTATE, 32'h1, 32'h1);
      rd(`URTEV_OFF_MODEMSTATE, 32'h0, 32'h0);
      rd(`URTEV_OFF_IDENT, `URTEV_IDENT_TOUT);
      rd(`URTEV_OFF_IDENT, `URTEV_IDENT_NONE);
      wr(`URTEV_OFF_IRQ_STAT, 32'h1);
      wait_irq(1'b0, 10);
      wait_irq(1'b1, 100);
      rd(`URTEV_OFF_RXHOLD, d[7:0]);
      rd(`URTEV_OFF_RXHOLD, d[15:8]);
      wr(`URTEV_OFF_IRQ_STAT, 32'h1);
      wait_irq(1'b0, 10);
      hold_irq(1'b0, 120);
      wr(`URTEV_OFF_EXTCTL2, 32'h40);
      rd(`URTEV_OFF_EXTCTL2, 32'h40, 32'h40);
      wait_irq(1'b1, 100);
      wr(`URTEV_OFF_IRQ_STAT, 32'h1);
      wait_irq(1'b0, 10);
      wait_irq(1'b1, 100);
      rd(`URTEV_OFF_IDENT, `URTEV_IDENT_TOUT);
      wr(`URTEV_OFF_EXTCTL2, 32'h0);
      wr(`URTEV_OFF_IRQ_STAT, 32'h7);
      // only power-of-two levels are programmed
      for (int i = 0; i < 5; i++) begin
         lvl = (fl[i] == 0) ? 1 : fl[i] * 4;
         wr(`URTEV_OFF_TRIGLVL, {24'h0, 4'(fl[i]), 4'h1});
         i_urtev_line_model.set_tx(7'(lvl - 1));
         repeat (3) @(posedge clk);
         chk(32'(dma_req_ff.tx_req), 0, "tx early");
         i_urtev_line_model.set_tx(7'(lvl));
         repeat (3) @(posedge clk);
         chk(32'(dma_req_ff.tx_req), 1, "tx missing");
         chk(32'(irq_ff), 0, "masked irq");
      end
      wr(`URTEV_OFF_IRQ_MASK, 32'h6);
      repeat (2) @(posedge clk);
      chk(32'(irq_ff), 1, "unmasked irq");
      i_urtev_line_model.set_tx(7'h40);
      repeat (3) @(posedge clk);
      chk(32'(dma_req_ff.tx_req), 1, "tx full");
      i_urtev_line_model.set_tx(7'h00);
      wr(`URTEV_OFF_IRQ_STAT, 32'h4);
      repeat (2) @(posedge clk);
      chk(32'(irq_ff), 0, "irq cleared");
      for (int k = 0; k < 4; k++) begin
         d = rnd();
         rxd[k] = d[7:0];
         if (k == 3) chk(32'(dma_req_ff.rx_req), 0, "rx early");
         i_urtev_line_model.send(rxd[k]);
         repeat (2) @(posedge clk);
      end
      chk(32'(dma_req_ff.rx_req), 1, "rx missing");
      chk(32'(irq_ff), 1, "rx irq");
      rd(`URTEV_OFF_FIFOSTAT, 32'h4, 32'h7F);
      rd(`URTEV_OFF_IRQ_STAT, 32'h2, 32'h7);
      for (int k = 0; k < 4; k++) rd(`URTEV_OFF_RXHOLD, rxd[k]);
      repeat (3) @(posedge clk);
      chk(32'(dma_req_ff.rx_req), 0, "rx stuck");
      tally_and_finish();
   end
endmodule
